// ### src/cia_irq_aggregator.sv
// Purpose: Interrupt aggregation for the codec: sticky flags, masks,
//   debounce of PLL and FLL lock and temperature sources, output polarity.
// Assumes: Classic Wishbone slave, one clock, synchronous reset.
// Notes: Registers are 16 bits in the low half of the 32-bit data bus.
//
// Added by the designer: the Wishbone interface to the registers.

`timescale 1ns/1ns
`default_nettype none

module cia_irq_aggregator
  import cia_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire cia_src_s src_i,
  input wire logic pin_five_i,
  input wire logic pin_six_i,
  output logic irq_o
);

  // Word index needs ten bits above the byte lanes
  if (ADDR_W < 12) begin : g_addr_check
    $error("cia_irq_aggregator: ADDR_W must be at least 12");
  end

  cia_state_s st_ff;
  cia_state_s nxt_st;

  logic req;
  logic wr_now;
  logic [9:0] idx;
  logic [15:0] wmask;
  logic [15:0] wdat;
  logic [15:0] lvl_hi;
  logic [15:0] lvl_lo;
  logic [15:0] set_hi;
  logic [15:0] set_lo;
  logic [15:0] clr_hi;
  logic [15:0] clr_lo;
  logic [15:0] rd_mux;
  logic [NUM_DB-1:0] db_raw;
  logic [NUM_DB-1:0] db_on;

  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[11:2];
  assign wdat = wb_dat_i[15:0];
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // A write lands on the edge where the master sees ack
  assign wr_now = req & wb_we_i & st_ff.ack;

  // Raw levels of the debounced sources, slot order follows DB_POS
  assign db_raw = {src_i.freq_loop_lock, src_i.third_pll_lock,
                   src_i.second_pll_lock, src_i.overtemp};

  always_comb begin
    for (int i = 0; i < NUM_DB; i++) begin
      db_on[i] = st_ff.debounce[DB_POS[i]];
    end
  end

  // Event levels of the second status word
  always_comb begin
    lvl_hi = 16'h0000;
    lvl_hi[POS_MIC_SHORT] = src_i.mic_short_over
                            ^ st_ff.mic_pol[POS_MIC_SHORT];
    lvl_hi[POS_MIC_DETECT] = src_i.mic_detect_over
                             ^ st_ff.mic_pol[POS_MIC_DETECT];
    lvl_hi[POS_FIFO_ERR] = src_i.fifo_error;
    lvl_hi[POS_LVL_LOCK] = src_i.level_lock;
    lvl_hi[POS_LVL_THRESH] = src_i.level_threshold;
    lvl_hi[POS_LVL_SAT] = src_i.level_saturation;
    lvl_hi[POS_LVL_PEAK] = src_i.level_peak_overload;
    lvl_hi[POS_LVL_GATE] = src_i.level_noise_gate;
    lvl_hi[POS_SEQ_DONE] = src_i.sequencer_done;
    lvl_hi[POS_DYN_ACT] = src_i.dynamics_activity;
    // Filtered value of each PLL, FLL or temperature source
    for (int i = 0; i < NUM_DB; i++) begin
      lvl_hi[DB_POS[i]] = st_ff.filt[i];
    end
  end

  // Pin events come from the synchronised copies only
  always_comb begin
    lvl_lo = 16'h0000;
    lvl_lo[POS_PIN_SIX] = st_ff.pin_sync[1];
    lvl_lo[POS_PIN_FIVE] = st_ff.pin_sync[0];
  end

  // Rising edge of a level is an event
  always_comb begin
    set_hi = lvl_hi & ~st_ff.ev_prev & BITS_FLAGS_HI;
    set_lo = lvl_lo & {14'h0000, ~st_ff.pin_prev} << POS_PIN_FIVE;
    set_lo = set_lo & BITS_FLAGS_LO;
  end

  // Write-one-to-clear strobes
  always_comb begin
    clr_hi = 16'h0000;
    clr_lo = 16'h0000;
    if (wr_now && idx == IDX_FLAGS_HI) begin
      clr_hi = wdat & wmask;
    end
    if (wr_now && idx == IDX_FLAGS_LO) begin
      clr_lo = wdat & wmask;
    end
  end

  // Read multiplexer; unmapped words read zero
  always_comb begin
    case (idx)
      IDX_FLAGS_LO: rd_mux = st_ff.flags_lo & BITS_FLAGS_LO;
      IDX_FLAGS_HI: rd_mux = st_ff.flags_hi & BITS_FLAGS_HI;
      IDX_MASK_LO: rd_mux = st_ff.mask_lo & BITS_MASK_LO;
      IDX_MASK_HI: rd_mux = st_ff.mask_hi & BITS_MASK_HI;
      IDX_OUT_CTL: rd_mux = st_ff.out_ctl & BITS_OUT_CTL;
      IDX_DEBOUNCE: rd_mux = st_ff.debounce & BITS_DEBOUNCE;
      IDX_MIC_POL: rd_mux = st_ff.mic_pol & BITS_MIC_POL;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;

    // Bus handshake: one wait cycle, ack drops after one cycle
    nxt_st.ack = req & ~st_ff.ack;
    // Only reads load the data register, so it stands until the next read
    if (req && !st_ff.ack && !wb_we_i) begin
      nxt_st.rdat = rd_mux;
    end

    // Pin synchronisers; the first stage feeds only the second
    nxt_st.pin_meta = {pin_six_i, pin_five_i};
    nxt_st.pin_sync = st_ff.pin_meta;
    nxt_st.pin_prev = st_ff.pin_sync;
    nxt_st.ev_prev = lvl_hi;

    // Debounce: a change is taken only after it stays stable long enough
    for (int i = 0; i < NUM_DB; i++) begin
      if (!db_on[i]) begin
        nxt_st.filt[i] = db_raw[i];
        nxt_st.cnt[i] = '0;
      end else if (db_raw[i] == st_ff.filt[i]) begin
        nxt_st.cnt[i] = '0;
      end else if (st_ff.cnt[i] == DB_LAST) begin
        nxt_st.filt[i] = db_raw[i];
        nxt_st.cnt[i] = '0;
      end else begin
        nxt_st.cnt[i] = st_ff.cnt[i] + DB_CW'(1);
      end
    end

    // Set wins over a clear in the same cycle so no event is lost
    nxt_st.flags_hi = ((st_ff.flags_hi & ~clr_hi) | set_hi)
                      & BITS_FLAGS_HI;
    nxt_st.flags_lo = ((st_ff.flags_lo & ~clr_lo) | set_lo)
                      & BITS_FLAGS_LO;

    // Plain read-write registers, byte lanes honoured
    if (wr_now) begin
      case (idx)
        IDX_MASK_LO: begin
          nxt_st.mask_lo = ((st_ff.mask_lo & ~wmask) | (wdat & wmask))
                           & BITS_MASK_LO;
        end
        IDX_MASK_HI: begin
          nxt_st.mask_hi = ((st_ff.mask_hi & ~wmask) | (wdat & wmask))
                           & BITS_MASK_HI;
        end
        IDX_OUT_CTL: begin
          nxt_st.out_ctl = ((st_ff.out_ctl & ~wmask) | (wdat & wmask))
                           & BITS_OUT_CTL;
        end
        IDX_DEBOUNCE: begin
          nxt_st.debounce = ((st_ff.debounce & ~wmask) | (wdat & wmask))
                            & BITS_DEBOUNCE;
        end
        IDX_MIC_POL: begin
          nxt_st.mic_pol = ((st_ff.mic_pol & ~wmask) | (wdat & wmask))
                           & BITS_MIC_POL;
        end
        default: begin
          nxt_st.mic_pol = st_ff.mic_pol;
        end
      endcase
    end

    // Output follows the new state, so it is registered yet current
    nxt_st.irq = (|(nxt_st.flags_hi & ~nxt_st.mask_hi)
                  | |(nxt_st.flags_lo & ~nxt_st.mask_lo))
                 ^ nxt_st.out_ctl[POS_IRQ_POL];
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
      st_ff.flags_hi <= RST_FLAGS;
      st_ff.flags_lo <= RST_FLAGS;
      st_ff.mask_lo <= RST_MASK_LO;
      st_ff.mask_hi <= RST_MASK_HI;
      st_ff.out_ctl <= RST_OUT_CTL;
      st_ff.debounce <= RST_DEBOUNCE;
      st_ff.mic_pol <= RST_MIC_POL;
      // Active-high default: idle output is low
      st_ff.irq <= 1'b0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = {16'h0000, st_ff.rdat};
  assign irq_o = st_ff.irq;

endmodule : cia_irq_aggregator

`default_nettype wire

// ### src/cia_pkg.sv
// Purpose: Shared constants and types for the codec interrupt aggregator.
// Assumes: 10 MHz register clock, Wishbone data 32 bits, registers 16 bits.
// Notes: Register offsets are word indices; byte address is four times.
package cia_pkg;

  // Register word indices; byte address = index * 4
  localparam logic [9:0] IDX_FLAGS_LO = 10'h230;
  localparam logic [9:0] IDX_FLAGS_HI = 10'h231;
  localparam logic [9:0] IDX_MASK_LO = 10'h238;
  localparam logic [9:0] IDX_MASK_HI = 10'h239;
  localparam logic [9:0] IDX_OUT_CTL = 10'h240;
  localparam logic [9:0] IDX_DEBOUNCE = 10'h248;
  localparam logic [9:0] IDX_MIC_POL = 10'h24A;

  // Implemented bits of each register; all others read zero
  localparam logic [15:0] BITS_FLAGS_LO = 16'h0030;
  localparam logic [15:0] BITS_FLAGS_HI = 16'hFFED;
  localparam logic [15:0] BITS_MASK_LO = 16'h0030;
  localparam logic [15:0] BITS_MASK_HI = 16'hFFFF;
  localparam logic [15:0] BITS_OUT_CTL = 16'h0001;
  localparam logic [15:0] BITS_DEBOUNCE = 16'h003F;
  localparam logic [15:0] BITS_MIC_POL = 16'hC000;

  // Values after reset
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [15:0] RST_MASK_LO = 16'h0030;
  localparam logic [15:0] RST_MASK_HI = 16'hFFFF;
  localparam logic [15:0] RST_OUT_CTL = 16'h0000;
  localparam logic [15:0] RST_DEBOUNCE = 16'h003F;
  localparam logic [15:0] RST_MIC_POL = 16'h0000;

  // Field positions, shared by flag, mask and debounce words; POS_IRQ_POL is the output control bit
  localparam int unsigned POS_PIN_SIX = 5;
  localparam int unsigned POS_PIN_FIVE = 4;
  localparam int unsigned POS_MIC_SHORT = 15;
  localparam int unsigned POS_MIC_DETECT = 14;
  localparam int unsigned POS_FIFO_ERR = 13;
  localparam int unsigned POS_LVL_LOCK = 12;
  localparam int unsigned POS_LVL_THRESH = 11;
  localparam int unsigned POS_LVL_SAT = 10;
  localparam int unsigned POS_LVL_PEAK = 9;
  localparam int unsigned POS_LVL_GATE = 8;
  localparam int unsigned POS_SEQ_DONE = 7;
  localparam int unsigned POS_DYN_ACT = 6;
  localparam int unsigned POS_FLL_LOCK = 5;
  localparam int unsigned POS_PLL3_LOCK = 3;
  localparam int unsigned POS_PLL2_LOCK = 2;
  localparam int unsigned POS_OVERTEMP = 0;
  localparam int unsigned POS_IRQ_POL = 0;

  // Debounced sources, slot n sits at this bit of the flag word
  localparam int unsigned NUM_DB = 4;
  localparam logic [3:0][3:0] DB_POS = {4'h5, 4'h3, 4'h2, 4'h0};

  // Debounce filter time
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DB_TIME_NS = 100000;
  localparam int unsigned DB_CYCLES = (DB_TIME_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int unsigned DB_CW = $clog2(DB_CYCLES + 1);
  localparam logic [DB_CW-1:0] DB_LAST = DB_CW'(DB_CYCLES - 1);

  // Event sources from the codec's own units, same clock
  typedef struct packed {
    logic mic_short_over;
    logic mic_detect_over;
    logic fifo_error;
    logic level_lock;
    logic level_threshold;
    logic level_saturation;
    logic level_peak_overload;
    logic level_noise_gate;
    logic sequencer_done;
    logic dynamics_activity;
    logic freq_loop_lock;
    logic third_pll_lock;
    logic second_pll_lock;
    logic overtemp;
  } cia_src_s;

  // Entire state of the aggregator
  typedef struct packed {
    logic ack;
    logic [15:0] rdat;
    logic [15:0] flags_lo;
    logic [15:0] flags_hi;
    logic [15:0] mask_lo;
    logic [15:0] mask_hi;
    logic [15:0] out_ctl;
    logic [15:0] debounce;
    logic [15:0] mic_pol;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_prev;
    logic [15:0] ev_prev;
    logic [NUM_DB-1:0] filt;
    logic [NUM_DB-1:0][DB_CW-1:0] cnt;
    logic irq;
  } cia_state_s;

endpackage : cia_pkg

// ### tb/cia_irq_aggregator_asserts.sv
// Purpose: Bus and reset checks on the aggregator ports.
// Assumes: ce_i high outside reset.
// Notes: Bound into every aggregator instance.
`timescale 1ns/1ns
`default_nettype none
module cia_irq_aggregator_asserts (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || !ce_i);
  wire req = wb_cyc_i && wb_stb_i;
  a_ack_follows_req: assert property (req && !wb_ack_o |=> wb_ack_o ##1
    !wb_ack_o) else $error("ack late or too long");
  a_ack_has_req: assert property (wb_ack_o |-> $past(req && !wb_ack_o))
    else $error("ack without request");
  a_idle_no_ack: assert property (!req |=> !wb_ack_o)
    else $error("ack while idle");
  a_held_req_ack: assert property (req [*2] |-> wb_ack_o)
    else $error("held request not acked");
  a_ack_within: assert property (req |-> ##[0:1] wb_ack_o)
    else $error("no ack within one cycle");
  a_upper_zero: assert property (wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  // Read data only moves with a read acknowledge
  a_dat_holds: assert property (!(wb_ack_o && !wb_we_i) |->
    $stable(wb_dat_o)) else $error("read data moved");
  a_reset_quiet: assert property (disable iff (1'h0) sys_rst_i |=>
    !wb_ack_o && !irq_o && wb_dat_o == 32'h0) else $error("reset not quiet");
  c_write: cover property (req && wb_we_i && wb_ack_o);
  c_read: cover property (req && !wb_we_i && wb_ack_o);
  c_irq: cover property ($rose(irq_o));
endmodule : cia_irq_aggregator_asserts
bind cia_irq_aggregator cia_irq_aggregator_asserts u_asserts (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire

// ### tb/cia_host_mon.sv
// Purpose: Host view of the interrupt line.
// Assumes: Host knows the polarity it programmed.
// Notes: Combinational, so no sampling delay.
`timescale 1ns/1ns
`default_nettype none
module cia_host_mon (
  input wire logic irq_i,
  input wire logic pol_i,
  output logic pending_o
);
  assign pending_o = irq_i ^ pol_i;
endmodule : cia_host_mon
`default_nettype wire

// ### tb/cia_irq_aggregator_tb_top.sv
// Purpose: Self-checking bench for the interrupt aggregator.
// Assumes: One bus request at a time, ce_i held high.
// Notes: One filtered source is timed at full debounce length.
`timescale 1ns/1ns
`default_nettype none
module cia_irq_aggregator_tb_top;
  import cia_pkg::*;
  logic clk_i = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic we = 1'h0;
  logic pol = 1'h0;
  logic [1:0] pins = 2'h0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat;
  logic ack, irq, pend;
  logic [15:0] rq, m;
  cia_src_s src = '0;
  int num_errors = 0;
  int num_checks = 0;
  logic [9:0] idx_t[7] = '{IDX_FLAGS_LO, IDX_FLAGS_HI, IDX_MASK_LO,
    IDX_MASK_HI, IDX_OUT_CTL, IDX_DEBOUNCE, IDX_MIC_POL};
  logic [15:0] rst_t[7] = '{16'h0000, 16'h0000, 16'h0030, 16'hFFFF,
    16'h0000, 16'h003F, 16'h0000};
  logic [15:0] bit_t[7] = '{BITS_FLAGS_LO, BITS_FLAGS_HI, BITS_MASK_LO,
    BITS_MASK_HI, BITS_OUT_CTL, BITS_DEBOUNCE, BITS_MIC_POL};
  always #50 clk_i = ~clk_i;
  cia_irq_aggregator dut (.clk_i(clk_i), .sys_rst_i(rst), .ce_i(1'h1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
    .src_i(src), .pin_five_i(pins[0]), .pin_six_i(pins[1]), .irq_o(irq));
  cia_host_mon u_host (.irq_i(irq), .pol_i(pol), .pending_o(pend));
  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [9:0] idx,
      input logic [15:0] d);
    int n;
    logic seen;
    n = 0;
    cyc <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    rq = dat[15:0];
    seen = ack;
    cyc <= 1'h0;
    @(posedge clk_i);
    if (seen !== 1'h1) begin
      num_errors++;
      wrap_up();
    end
  endtask : bus
  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    bus(1'h1, idx, d);
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [15:0] e);
    bus(1'h0, idx, 16'h0000);
    chk(rq, e);
  endtask : rd
  // Source slot in the event struct to flag bit, bits 4 and 1 skipped
  function automatic int fpos(input int i);
    return (i > 2) ? i + 2 : ((i == 0) ? 0 : i + 1);
  endfunction : fpos
  initial begin
    void'($urandom(1711));
    repeat (2) @(posedge clk_i);
    rst <= 1'h0;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++) rd(idx_t[i], rst_t[i]);
    chk({15'h0000, pend}, 16'h0000);
    wr(10'h232, 16'hFFFF);
    rd(10'h232, 16'h0000);
    for (int i = 2; i < 7; i++) begin
      m = 16'($urandom()) | 16'h0012;
      wr(idx_t[i], m);
      rd(idx_t[i], m & bit_t[i]);
    end
    wr(IDX_MIC_POL, 16'h0000);
    wr(IDX_OUT_CTL, 16'h0000);
    wr(IDX_DEBOUNCE, 16'h0012);
    wr(IDX_MASK_LO, 16'h0030);
    wr(IDX_FLAGS_HI, 16'hFFFF);
    wr(IDX_FLAGS_LO, 16'hFFFF);
    wr(IDX_MIC_POL, 16'hC000);
    rd(IDX_FLAGS_HI, 16'hC000);
    wr(IDX_MIC_POL, 16'h0000);
    wr(IDX_FLAGS_HI, 16'hFFFF);
    rd(IDX_FLAGS_HI, 16'h0000);
    for (int i = 0; i < 14; i++) begin
      m = 16'($urandom()) | 16'h0012;
      wr(IDX_MASK_HI, m);
      src <= cia_src_s'(14'h0001 << i);
      repeat (2) @(posedge clk_i);
      rd(IDX_FLAGS_HI, 16'h0001 << fpos(i));
      chk({15'h0000, pend}, {15'h0000, ~m[fpos(i)]});
      src <= '0;
      wr(IDX_FLAGS_HI, 16'h0000);
      rd(IDX_FLAGS_HI, 16'h0001 << fpos(i));
      wr(IDX_FLAGS_HI, 16'h0001 << fpos(i));
      rd(IDX_FLAGS_HI, 16'h0000);
      chk({15'h0000, pend}, 16'h0000);
    end
    wr(IDX_MASK_HI, 16'hFFFE);
    src <= cia_src_s'(14'h0001);
    for (int p = 1; p >= 0; p--) begin
      wr(IDX_OUT_CTL, 16'(p));
      pol <= 1'(p);
      @(posedge clk_i);
      chk({15'h0000, irq}, 16'(1 - p));
      chk({15'h0000, pend}, 16'h0001);
    end
    src <= '0;
    wr(IDX_FLAGS_HI, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      pins[p] <= 1'h1;
      repeat (5) @(posedge clk_i);
      rd(IDX_FLAGS_LO, 16'h0010 << p);
      wr(IDX_MASK_LO, 16'h0020 >> p);
      chk({15'h0000, pend}, 16'h0001);
      wr(IDX_FLAGS_LO, 16'h0010 << p);
      chk({15'h0000, pend}, 16'h0000);
      pins[p] <= 1'h0;
      wr(IDX_MASK_LO, 16'h0030);
    end
    // Let every filter settle low before timing one
    wr(IDX_DEBOUNCE, 16'h003F);
    repeat (1100) @(posedge clk_i);
    wr(IDX_FLAGS_HI, 16'hFFFF);
    src <= cia_src_s'(14'h0001);
    repeat (990) @(posedge clk_i);
    rd(IDX_FLAGS_HI, 16'h0000);
    repeat (20) @(posedge clk_i);
    rd(IDX_FLAGS_HI, 16'h0001);
    wrap_up();
  end
endmodule : cia_irq_aggregator_tb_top
`default_nettype wire
